// ==== rtl/ssi_consts.svh ====
// offsets, field positions, reset values and timing counts of the sync and interface select block
// assumes a 125 MHz system clock and an 8-bit register port
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

`define SSI_OFS_POL 8'h0F
`define SSI_OFS_STATUS 8'h11
`define SSI_OFS_CTRL 8'h12
`define SSI_OFS_THRESH 8'h13
`define SSI_OFS_SCAN 8'h14

`define SSI_ST_HS_DET 7
`define SSI_ST_SOG_DET 6
`define SSI_ST_VS_DET 5
`define SSI_ST_DCLK_DET 4
`define SSI_ST_AI 3
`define SSI_ST_AHS 2
`define SSI_ST_AVS 1

`define SSI_CT_IF_OV 7
`define SSI_CT_IF_SEL 6
`define SSI_CT_HS_OV 5
`define SSI_CT_HS_SEL 4
`define SSI_CT_VS_OV 3
`define SSI_CT_VS_SEL 2
`define SSI_CT_COAST_SEL 1
`define SSI_CT_PWR_N 0

`define SSI_SC_SCAN_EN 2
`define SSI_SC_COAST_POL_OV 1
`define SSI_SC_HS_POL_OV 0

`define SSI_PL_HS_POL 7
`define SSI_PL_COAST_POL 6

`define SSI_RST_POL 8'hC0
`define SSI_MASK_POL 8'hC0
`define SSI_RST_CTRL 8'h01
`define SSI_RST_THRESH 8'h20
`define SSI_RST_SCAN 8'h00

`define SSI_CLK_MHZ 125
`define SSI_TICK_MHZ 5
`define SSI_TICK_CYCLES (`SSI_CLK_MHZ / `SSI_TICK_MHZ)
`define SSI_LINE_TIMEOUT_US 100
`define SSI_FRAME_TIMEOUT_MS 50
`define SSI_LINE_TIMEOUT_CYCLES (`SSI_LINE_TIMEOUT_US * `SSI_CLK_MHZ)
`define SSI_FRAME_TIMEOUT_CYCLES (`SSI_FRAME_TIMEOUT_MS * 1000 * `SSI_CLK_MHZ)

`endif

// ==== rtl/ssi_pkg.sv ====
// types shared by the sync and interface select block
// assumes nothing beyond the constants header
`default_nettype none
package ssi_pkg;
  typedef logic [7:0] ssi_byte_t;
  typedef logic [22:0] ssi_tmo_t;
  typedef enum logic [1:0]
  {
    SSI_ACT_IDLE = 2'b01,
    SSI_ACT_SEEN = 2'b10
  } ssi_act_state_t;
endpackage
`default_nettype wire

// ==== rtl/ssi_sep_if.sv ====
// carrier between the top and the sync separator
// assumes one clock domain shared by both ends
`default_nettype none
interface ssi_sep_if;
  ssi_pkg::ssi_byte_t threshold;
  logic tick;
  logic comp_sync;
  logic frame_sync;
  modport sep
  (
    input threshold,
    input tick,
    input comp_sync,
    output frame_sync
  );
  modport ctl
  (
    output threshold,
    output tick,
    output comp_sync,
    input frame_sync
  );
endinterface
`default_nettype wire

// ==== rtl/ssi_act_detect.sv ====
// activity detector: flags a toggling input, drops it after a quiet window
// assumes the input is synchronous to clock_in
`default_nettype none
module ssi_act_detect #(
  parameter ssi_pkg::ssi_tmo_t TIMEOUT = 23'd12500
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic enable_in,
  input wire logic sig_in,
  output logic active_out
);
  ssi_pkg::ssi_act_state_t state_reg;
  ssi_pkg::ssi_tmo_t quiet_reg;
  logic sig_d_reg;
  logic primed_reg;
  logic edge_seen;

  // first sample after reset only primes, so an idle-high pin gives no false edge
  assign edge_seen = primed_reg & (sig_in ^ sig_d_reg);

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      sig_d_reg <= 1'b0;
      primed_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      sig_d_reg <= sig_in;
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_reg <= ssi_pkg::SSI_ACT_IDLE;
      quiet_reg <= '0;
    end
    else if (ce_in)
    begin
      if (!enable_in)
      begin
        state_reg <= ssi_pkg::SSI_ACT_IDLE;
        quiet_reg <= '0;
      end
      else if (edge_seen)
      begin
        state_reg <= ssi_pkg::SSI_ACT_SEEN;
        quiet_reg <= '0;
      end
      else
      begin
        case (state_reg)
          ssi_pkg::SSI_ACT_SEEN:
          begin
            if (quiet_reg >= TIMEOUT - 23'd1)
            begin
              state_reg <= ssi_pkg::SSI_ACT_IDLE;
              quiet_reg <= '0;
            end
            else
              quiet_reg <= quiet_reg + 23'd1;
          end
          ssi_pkg::SSI_ACT_IDLE:
            quiet_reg <= '0;
          default:
          begin
            state_reg <= ssi_pkg::SSI_ACT_IDLE;
            quiet_reg <= '0;
          end
        endcase
      end
    end
  end

  assign active_out = (state_reg == ssi_pkg::SSI_ACT_SEEN);
endmodule
`default_nettype wire

// ==== rtl/ssi_sync_sep.sv ====
// sync separator: low-pass on composite sync to recover frame sync
// assumes tick is a one-cycle pulse at 5 MHz
`default_nettype none
module ssi_sync_sep
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  ssi_sep_if.sep sep
);
  ssi_pkg::ssi_byte_t cnt_reg;
  logic out_reg;
  logic [8:0] cnt_inc;

  assign cnt_inc = {1'b0, cnt_reg} + 9'd1;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sep.comp_sync == out_reg)
        cnt_reg <= '0;
      else if (sep.tick)
      begin
        if (cnt_inc >= {1'b0, sep.threshold})
        begin
          out_reg <= ~out_reg;
          cnt_reg <= '0;
        end
        else
          cnt_reg <= cnt_inc[7:0];
      end
    end
  end

  assign sep.frame_sync = out_reg;
endmodule
`default_nettype wire

// ==== rtl/ssi_top.sv ====
// sync source and active interface selection with its control registers
// assumes all pins and the register port are synchronous to clock_in
// Contract
// - status bit 4 shows digital clock activity, 1 when present
// - analog detected is OR of bits 7,6,5; digital from bit 4
// - auto: digital only gives 1, analog only 0, both copies control bit 6
// - interface override bit 7 forces active interface to control bit 6
// - active interface 0 analog, 1 digital; no activity enters seek mode unless override bit 7 is set
// - auto: green sync only gives 1, line sync only 0, else control bit 4
// - line sync override bit 5 forces active line sync to bit 4
// - line sync select 0 is sync pin, 1 is green embedded sync
// - auto frame sync follows frame sync detect, preferring the pin
// - frame sync override bit 3 forces active frame sync to bit 2
// - frame sync select 0 is pin, 1 is separator output
// - interface override and select reset to 0; select 0 analog
// - line and frame override and select bits reset to 0
// - coast select 0 coast pin, 1 the chosen frame sync
// - control bit 0 low powers down, stops detection; resets to 1
// - separator toggles after threshold 5 MHz ticks; threshold resets 32
// - scan enable is bit 2 of 0x14, resets to 0
// - coast polarity override bit 1 picks user polarity, resets 0
// - line sync polarity override bit 0 picks user polarity
// - line sync detect reads 0 for a static input
// - coast polarity bit 0 active low, 1 active high, resets 1
`include "ssi_consts.svh"
`default_nettype none
module ssi_top #(
  parameter ssi_pkg::ssi_tmo_t LINE_TIMEOUT = 23'(`SSI_LINE_TIMEOUT_CYCLES),
  parameter ssi_pkg::ssi_tmo_t FRAME_TIMEOUT = 23'(`SSI_FRAME_TIMEOUT_CYCLES)
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic line_sync_in,
  input wire logic green_embedded_sync_in,
  input wire logic frame_sync_in,
  input wire logic dclk_in,
  input wire logic coast_in,
  input wire logic line_pol_detected_in,
  input wire logic coast_pol_detected_in,
  output logic active_iface_flag_out,
  output logic active_line_sync_flag_out,
  output logic active_frame_sync_flag_out,
  output logic seek_mode_out,
  output logic full_power_off_n_out,
  output logic scan_enable_out,
  output logic line_sync_sel_out,
  output logic frame_sync_sel_out,
  output logic coast_sel_out,
  output logic line_sync_polarity_out,
  output logic hold_input_polarity_out
);
  ssi_pkg::ssi_byte_t pol_reg;
  ssi_pkg::ssi_byte_t ctrl_reg;
  ssi_pkg::ssi_byte_t thresh_reg;
  ssi_pkg::ssi_byte_t scan_reg;
  ssi_pkg::ssi_byte_t status_reg;
  ssi_pkg::ssi_byte_t status_next;
  ssi_pkg::ssi_byte_t rdata_next;
  logic [4:0] tick_cnt_reg;
  logic tick;
  logic hs_det;
  logic sog_det;
  logic vs_det;
  logic dclk_det;
  logic ana_det;
  logic ai_next;
  logic ahs_next;
  logic avs_next;
  logic seek_next;
  logic frame_sel_src;

  ssi_sep_if sep_bus();

  // shared picker for the interface and line sync selections with override
  function automatic logic pick_src(input logic ov, input logic only_a, input logic only_b, input logic sel);
    logic r;
    r = sel;
    if (!ov && only_b)
      r = 1'b1;
    else if (!ov && only_a)
      r = 1'b0;
    return r;
  endfunction

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      ctrl_reg <= `SSI_RST_CTRL;
    else if (ce_in && reg_wr_in && reg_addr_in == `SSI_OFS_CTRL)
      ctrl_reg <= reg_wdata_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      thresh_reg <= `SSI_RST_THRESH;
    else if (ce_in && reg_wr_in && reg_addr_in == `SSI_OFS_THRESH)
      thresh_reg <= reg_wdata_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      scan_reg <= `SSI_RST_SCAN;
    else if (ce_in && reg_wr_in && reg_addr_in == `SSI_OFS_SCAN)
      scan_reg <= reg_wdata_in & 8'h07;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pol_reg <= `SSI_RST_POL;
    else if (ce_in && reg_wr_in && reg_addr_in == `SSI_OFS_POL)
      pol_reg <= reg_wdata_in & `SSI_MASK_POL;
  end

  // 5 MHz tick for the separator, derived rather than a second clock
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      tick_cnt_reg <= '0;
    else if (ce_in)
    begin
      if (tick_cnt_reg == 5'(`SSI_TICK_CYCLES - 1))
        tick_cnt_reg <= '0;
      else
        tick_cnt_reg <= tick_cnt_reg + 5'd1;
    end
  end
  assign tick = (tick_cnt_reg == 5'(`SSI_TICK_CYCLES - 1));

  ssi_act_detect #(.TIMEOUT(LINE_TIMEOUT)) u_hs_det
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .enable_in(ctrl_reg[`SSI_CT_PWR_N]),
    .sig_in(line_sync_in),
    .active_out(hs_det)
  );

  ssi_act_detect #(.TIMEOUT(LINE_TIMEOUT)) u_sog_det
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .enable_in(ctrl_reg[`SSI_CT_PWR_N]),
    .sig_in(green_embedded_sync_in),
    .active_out(sog_det)
  );

  // frame rate is slow, so this window is much longer
  ssi_act_detect #(.TIMEOUT(FRAME_TIMEOUT)) u_vs_det
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .enable_in(ctrl_reg[`SSI_CT_PWR_N]),
    .sig_in(frame_sync_in),
    .active_out(vs_det)
  );

  // a pixel clock above half of clock_in aliases; sampled detection is a limitation
  ssi_act_detect #(.TIMEOUT(LINE_TIMEOUT)) u_dclk_det
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .enable_in(ctrl_reg[`SSI_CT_PWR_N]),
    .sig_in(dclk_in),
    .active_out(dclk_det)
  );

  assign sep_bus.threshold = thresh_reg;
  assign sep_bus.tick = tick;
  assign sep_bus.comp_sync = green_embedded_sync_in;

  ssi_sync_sep u_sep
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .sep(sep_bus.sep)
  );

  assign ana_det = hs_det | sog_det | vs_det;

  always_comb
  begin
    ai_next = pick_src(ctrl_reg[`SSI_CT_IF_OV], ana_det && !dclk_det, dclk_det && !ana_det,
                       ctrl_reg[`SSI_CT_IF_SEL]);
    ahs_next = pick_src(ctrl_reg[`SSI_CT_HS_OV], hs_det && !sog_det, sog_det && !hs_det,
                        ctrl_reg[`SSI_CT_HS_SEL]);
    avs_next = ctrl_reg[`SSI_CT_VS_OV] ? ctrl_reg[`SSI_CT_VS_SEL] : !vs_det;
    seek_next = !ctrl_reg[`SSI_CT_IF_OV] && !ana_det && !dclk_det;
    status_next = '0;
    status_next[`SSI_ST_HS_DET] = hs_det;
    status_next[`SSI_ST_SOG_DET] = sog_det;
    status_next[`SSI_ST_VS_DET] = vs_det;
    status_next[`SSI_ST_DCLK_DET] = dclk_det;
    status_next[`SSI_ST_AI] = ai_next;
    status_next[`SSI_ST_AHS] = ahs_next;
    status_next[`SSI_ST_AVS] = avs_next;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      status_reg <= '0;
      seek_mode_out <= 1'b0;
    end
    else if (ce_in)
    begin
      status_reg <= status_next;
      seek_mode_out <= seek_next;
    end
  end

  assign frame_sel_src = status_reg[`SSI_ST_AVS] ? sep_bus.frame_sync : frame_sync_in;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      line_sync_sel_out <= 1'b0;
      frame_sync_sel_out <= 1'b0;
      coast_sel_out <= 1'b0;
    end
    else if (ce_in)
    begin
      line_sync_sel_out <= status_reg[`SSI_ST_AHS] ? green_embedded_sync_in : line_sync_in;
      frame_sync_sel_out <= frame_sel_src;
      coast_sel_out <= ctrl_reg[`SSI_CT_COAST_SEL] ? frame_sel_src : coast_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      line_sync_polarity_out <= 1'b1;
      hold_input_polarity_out <= 1'b1;
    end
    else if (ce_in)
    begin
      line_sync_polarity_out <= scan_reg[`SSI_SC_HS_POL_OV] ? pol_reg[`SSI_PL_HS_POL] : line_pol_detected_in;
      hold_input_polarity_out <= scan_reg[`SSI_SC_COAST_POL_OV] ? pol_reg[`SSI_PL_COAST_POL]
                                                                 : coast_pol_detected_in;
    end
  end

  always_comb
  begin
    case (reg_addr_in)
      `SSI_OFS_POL: rdata_next = pol_reg;
      `SSI_OFS_STATUS: rdata_next = status_reg;
      `SSI_OFS_CTRL: rdata_next = ctrl_reg;
      `SSI_OFS_THRESH: rdata_next = thresh_reg;
      `SSI_OFS_SCAN: rdata_next = scan_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (ce_in && reg_rd_in)
      reg_rdata_out <= rdata_next;
  end

  assign active_iface_flag_out = status_reg[`SSI_ST_AI];
  assign active_line_sync_flag_out = status_reg[`SSI_ST_AHS];
  assign active_frame_sync_flag_out = status_reg[`SSI_ST_AVS];
  assign full_power_off_n_out = ctrl_reg[`SSI_CT_PWR_N];
  assign scan_enable_out = scan_reg[`SSI_SC_SCAN_EN];
endmodule
`default_nettype wire

// ==== tb/ssi_assertions.sv ====
// checker for the selection block, fed only from the top's ports
// assumes it is bound into ssi_top; the control, scan and polarity registers are mirrored here
`default_nettype none
module ssi_assertions
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic coast_in,
  input wire logic active_iface_flag_out,
  input wire logic active_line_sync_flag_out,
  input wire logic active_frame_sync_flag_out,
  input wire logic seek_mode_out,
  input wire logic full_power_off_n_out,
  input wire logic scan_enable_out,
  input wire logic coast_sel_out,
  input wire logic line_sync_polarity_out,
  input wire logic hold_input_polarity_out
);
  logic [7:0] ctrl_reg;
  logic [7:0] scan_reg;
  logic [7:0] pol_reg;
  logic [2:0] age_reg;
  logic wr_hit;
  logic settled;
  assign wr_hit = ce_in & reg_wr_in;
  // outputs trail a write by up to three edges, so wait four
  assign settled = age_reg[2];
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ctrl_reg <= 8'h01;
      scan_reg <= 8'h00;
      pol_reg <= 8'hC0;
    end
    else if (wr_hit && reg_addr_in == 8'h12)
      ctrl_reg <= reg_wdata_in;
    else if (wr_hit && reg_addr_in == 8'h14)
      scan_reg <= reg_wdata_in;
    else if (wr_hit && reg_addr_in == 8'h0F)
      pol_reg <= reg_wdata_in;
  end
  always_ff @(posedge clock_in)
  begin
    if (rst_in || wr_hit)
      age_reg <= 3'h0;
    else if (ce_in && !age_reg[2])
      age_reg <= age_reg + 3'h1;
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  property p_if_ovr;
    settled && ctrl_reg[7] |-> active_iface_flag_out == ctrl_reg[6];
  endproperty
  a_if_ovr: assert property (p_if_ovr) else $error("forced interface flag wrong");
  property p_hs_ovr;
    settled && ctrl_reg[5] |-> active_line_sync_flag_out == ctrl_reg[4];
  endproperty
  a_hs_ovr: assert property (p_hs_ovr) else $error("forced line sync flag wrong");
  property p_vs_ovr;
    settled && ctrl_reg[3] |-> active_frame_sync_flag_out == ctrl_reg[2];
  endproperty
  a_vs_ovr: assert property (p_vs_ovr) else $error("forced frame sync flag wrong");
  property p_seek_ovr;
    settled && ctrl_reg[7] |-> !seek_mode_out;
  endproperty
  a_seek_ovr: assert property (p_seek_ovr) else $error("seek while interface forced");
  property p_pwr;
    wr_hit && reg_addr_in == 8'h12 |=> full_power_off_n_out == ctrl_reg[0];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit not taken");
  property p_scan;
    wr_hit && reg_addr_in == 8'h14 |=> scan_enable_out == scan_reg[2];
  endproperty
  a_scan: assert property (p_scan) else $error("scan enable not taken");
  property p_coast_pol;
    settled && scan_reg[1] |-> hold_input_polarity_out == pol_reg[6];
  endproperty
  a_coast_pol: assert property (p_coast_pol) else $error("user coast polarity ignored");
  property p_line_pol;
    settled && scan_reg[0] |-> line_sync_polarity_out == pol_reg[7];
  endproperty
  a_line_pol: assert property (p_line_pol) else $error("user line polarity ignored");
  property p_coast_sel;
    settled && !ctrl_reg[1] && $stable(coast_in) && coast_in == $past(coast_in, 2) |-> coast_sel_out == coast_in;
  endproperty
  a_coast_sel: assert property (p_coast_sel) else $error("coast pin not selected");
endmodule
`default_nettype wire

// ==== tb/ssi_src_model.sv ====
// video source stand-in: sync and clock lines that toggle or stand still
// assumes the bench picks the running lines and the level of idle ones
`default_nettype none
module ssi_src_model
(
  input wire logic clock_in,
  input wire logic [3:0] run_in,
  input wire logic idle_lvl_in,
  output logic line_sync_out,
  output logic green_sync_out,
  output logic frame_sync_out,
  output logic dclk_out
);
  logic [1:0] cnt_reg = 2'h0;
  logic phase_reg = 1'b0;
  // a toggle every four cycles stays well inside the shortened timeouts
  always_ff @(posedge clock_in)
  begin
    cnt_reg <= cnt_reg + 2'h1;
    if (cnt_reg == 2'h3)
      phase_reg <= ~phase_reg;
  end
  assign line_sync_out = run_in[3] ? phase_reg : idle_lvl_in;
  assign green_sync_out = run_in[2] ? phase_reg : idle_lvl_in;
  assign frame_sync_out = run_in[1] ? phase_reg : idle_lvl_in;
  assign dclk_out = run_in[0] ? phase_reg : idle_lvl_in;
endmodule
`default_nettype wire

// ==== tb/ssi_top_bench.sv ====
// self-checking bench for the selection block with shortened timeouts
// assumes the source model on the pins and the checker bound below
`default_nettype none
module ssi_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] act; logic [7:0] ctrl; logic [2:0] exp;} ssi_row_t;
  logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, v;
  logic line_sync_in, green_embedded_sync_in, frame_sync_in, dclk_in, coast_in = 1'b1;
  logic line_pol_detected_in = 1'b1, coast_pol_detected_in = 1'b0, lvl = 1'b1;
  logic active_iface_flag_out, active_line_sync_flag_out, active_frame_sync_flag_out, seek_mode_out;
  logic full_power_off_n_out, scan_enable_out, line_sync_sel_out, frame_sync_sel_out, coast_sel_out;
  logic line_sync_polarity_out, hold_input_polarity_out;
  logic [3:0] run = 4'h0, det;
  int err_total = 0, samples_checked = 0, n;
  // act = line, green, frame, dclk running; exp = interface, line, frame flags
  ssi_row_t rows [14] = '{'{4'h0, 8'h01, 3'h1}, '{4'h1, 8'h01, 3'h5}, '{4'h8, 8'h01, 3'h1},
    '{4'h4, 8'h01, 3'h3}, '{4'hC, 8'h11, 3'h3}, '{4'hF, 8'h41, 3'h4}, '{4'hF, 8'h01, 3'h0},
    '{4'h1, 8'h81, 3'h1}, '{4'h8, 8'hC1, 3'h5}, '{4'h4, 8'h21, 3'h1}, '{4'hA, 8'h31, 3'h2},
    '{4'h0, 8'h09, 3'h0}, '{4'h2, 8'h0D, 3'h1}, '{4'hF, 8'h00, 3'h1}};
  logic [7:0] ra [5] = '{8'h0F, 8'h12, 8'h13, 8'h14, 8'h30};
  logic [7:0] re [5] = '{8'hC0, 8'h01, 8'h20, 8'h00, 8'h00};
  always #4 clock_in = ~clock_in;
  ssi_top #(.LINE_TIMEOUT(23'd50), .FRAME_TIMEOUT(23'd200)) i_dut (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .line_sync_in(line_sync_in),
    .green_embedded_sync_in(green_embedded_sync_in), .frame_sync_in(frame_sync_in), .dclk_in(dclk_in),
    .coast_in(coast_in), .line_pol_detected_in(line_pol_detected_in), .coast_pol_detected_in(coast_pol_detected_in),
    .active_iface_flag_out(active_iface_flag_out), .active_line_sync_flag_out(active_line_sync_flag_out),
    .active_frame_sync_flag_out(active_frame_sync_flag_out), .seek_mode_out(seek_mode_out),
    .full_power_off_n_out(full_power_off_n_out), .scan_enable_out(scan_enable_out),
    .line_sync_sel_out(line_sync_sel_out), .frame_sync_sel_out(frame_sync_sel_out), .coast_sel_out(coast_sel_out),
    .line_sync_polarity_out(line_sync_polarity_out), .hold_input_polarity_out(hold_input_polarity_out));
  ssi_src_model i_src (.clock_in(clock_in), .run_in(run), .idle_lvl_in(lvl), .line_sync_out(line_sync_in),
    .green_sync_out(green_embedded_sync_in), .frame_sync_out(frame_sync_in), .dclk_out(dclk_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    // idle-high lines must not flag straight after reset
    repeat (4) @(posedge clock_in);
    rd(8'h11, v);
    check(v, 8'h02);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clock_in);
      run <= rows[i].act;
      wr(8'h12, rows[i].ctrl);
      // frame detector needs its full quiet window to drop
      repeat (300) @(posedge clock_in);
      #1;
      det = rows[i].act & {4{rows[i].ctrl[0]}};
      check({5'h00, active_iface_flag_out, active_line_sync_flag_out, active_frame_sync_flag_out},
        {5'h00, rows[i].exp});
      check({7'h00, seek_mode_out}, {7'h00, ~|det & ~rows[i].ctrl[7]});
      rd(8'h11, v);
      check(v & 8'hFE, {det, rows[i].exp, 1'b0});
      $display("row %0d done", i);
    end
    @(posedge clock_in);
    run <= 4'h0;
    lvl <= 1'b0;
    rst_in <= 1'b1;
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    check({6'h00, full_power_off_n_out, scan_enable_out}, 8'h02);
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], v);
      check(v, re[i]);
    end
    repeat (300) @(posedge clock_in);
    wr(8'h11, 8'hFF);
    rd(8'h11, v);
    check(v, 8'h02);
    $display("reset test done");
    wr(8'h14, 8'hFF);
    rd(8'h14, v);
    check(v, 8'h07);
    wr(8'h0F, 8'h7F);
    rd(8'h0F, v);
    check(v, 8'h40);
    check({6'h00, line_sync_polarity_out, hold_input_polarity_out}, 8'h01);
    // let the checker's polarity properties see the forced values
    repeat (6) @(posedge clock_in);
    wr(8'h14, 8'h00);
    repeat (4) @(posedge clock_in);
    #1;
    check({6'h00, line_sync_polarity_out, hold_input_polarity_out}, 8'h02);
    $display("polarity test done");
    wr(8'h12, 8'h0D);
    // threshold above the widest line pulse
    wr(8'h13, 8'h03);
    repeat (10) @(posedge clock_in);
    lvl <= 1'b1;
    n = 0;
    while (frame_sync_sel_out !== 1'b1 && n < 200)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      test_done();
    end
    check({7'h00, n >= 50 && n <= 80}, 8'h01);
    coast_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    check({7'h00, coast_sel_out}, 8'h00);
    check({7'h00, line_sync_sel_out}, 8'h01);
    wr(8'h12, 8'h0F);
    repeat (3) @(posedge clock_in);
    #1;
    check({7'h00, coast_sel_out}, 8'h01);
    $display("separator test done");
    test_done();
  end
endmodule
bind ssi_top ssi_assertions i_chk (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .coast_in(coast_in),
  .active_iface_flag_out(active_iface_flag_out), .active_line_sync_flag_out(active_line_sync_flag_out),
  .active_frame_sync_flag_out(active_frame_sync_flag_out), .seek_mode_out(seek_mode_out),
  .full_power_off_n_out(full_power_off_n_out), .scan_enable_out(scan_enable_out), .coast_sel_out(coast_sel_out),
  .line_sync_polarity_out(line_sync_polarity_out), .hold_input_polarity_out(hold_input_polarity_out));
`default_nettype wire
